// ---- inc/acc_pkg.sv ----
package acc_pkg;
   // Word and byte widths of the capture port
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int BIT_CNT_W = 5;
   localparam logic [4:0] WORD_BITS = 5'h10;
   // Depth of the word queue between shifter and parallel port
   localparam int FIFO_DEPTH = 8;
   // Output mode codes on the mode select port
   localparam logic [1:0] MODE_SELF = 2'h0;
   localparam logic [1:0] MODE_EXT = 2'h1;
   localparam logic [1:0] MODE_ASYNC = 2'h2;
   // Decimation: 2**(sel+1) ready pulses, sel 0..11
   localparam int DEC_CNT_W = 13;
   localparam logic [3:0] DEC_SEL_MAX = 4'hb;
   localparam logic [DEC_CNT_W-1:0] DEC_ONE = 13'h0001;
   // Baud divider: divide by 2**exp, exp 8..12
   localparam int BAUD_CNT_W = 12;
   localparam logic [3:0] BAUD_EXP_MIN = 4'h8;
   localparam logic [3:0] BAUD_EXP_MAX = 4'hc;
   // Character frame: start, eight data, two stop
   localparam int CHAR_START_BITS = 1;
   localparam int CHAR_DATA_BITS = 8;
   localparam int CHAR_STOP_BITS = 2;
   localparam int CHAR_FRAME_BITS = CHAR_START_BITS + CHAR_DATA_BITS + CHAR_STOP_BITS;
   // Reference oscillator for the baud table, in MHz
   localparam real REF_OSC_MHZ = 4.9152;
   // System clock
   localparam int CLK_PERIOD_NS = 40;
   // Capture states
   typedef enum logic [1:0] {CAP_IDLE, CAP_SHIFT, CAP_SKIP} acc_cap_type;
endpackage

// ---- src/acc_baud_div.sv ----
`timescale 1ns/100ps
module acc_baud_div (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Divide exponent, 8..12
   input  wire logic [3:0] baud_exp,
   // Divided clock
   output logic            baud_clk
);
   logic [acc_pkg::BAUD_CNT_W-1:0] div_cnt_reg;  // Free running divider
   logic [3:0]                     exp_sel;      // Clamped exponent

   // Out of range exponents fall back to the nearest legal one
   always_comb begin
      if (baud_exp < acc_pkg::BAUD_EXP_MIN) begin
         exp_sel = acc_pkg::BAUD_EXP_MIN;
      end else if (baud_exp > acc_pkg::BAUD_EXP_MAX) begin
         exp_sel = acc_pkg::BAUD_EXP_MAX;
      end else begin
         exp_sel = baud_exp;
      end
   end

   // Divider chain
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_reg <= '0;
      end else begin
         div_cnt_reg <= div_cnt_reg + 1'b1;
      end
   end

   // power of two
   // Bit exp-1 of the chain is a square wave of period 2**exp
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         baud_clk <= 1'b0;
      end else begin
         baud_clk <= div_cnt_reg[exp_sel - 4'h1];
      end
   end

   a_baud_square: assert property (@(posedge clk) disable iff (!rst_n)
      div_cnt_reg == '0 && $past(div_cnt_reg) != '0 && baud_exp == acc_pkg::BAUD_EXP_MIN
      |=> $fell(baud_clk))
      else $error("baud clock did not fall at divider wrap");
endmodule

// ---- src/acc_capture.sv ----
`timescale 1ns/100ps
module acc_capture (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Configuration
   input  wire logic [1:0]  mode_sel,
   input  wire logic [3:0]  decim_sel,
   input  wire logic        decim_drive_en,
   input  wire logic        lockout_en,
   input  wire logic        byte_wide_en,
   input  wire logic        baud_clk_en,
   input  wire logic [3:0]  baud_exp,
   // Converter side
   input  wire logic        word_ready_n,
   input  wire logic        serial_clock_conv,
   input  wire logic        serial_data_out,
   output logic             select_line_bar,
   output logic             serial_clock_drive,
   // Remote controller side
   input  wire logic        remote_select_n,
   input  wire logic        serial_clock_in,
   input  wire logic        read_acknowledge,
   input  wire logic        read_enable_n,
   input  wire logic        byte_select,
   output logic             parallel_ready_flag,
   output logic             word_ready_bar,
   output logic             serial_out_pin,
   output logic             clear_to_send,
   output logic [15:0]      par_data_o,
   output logic [1:0]       par_data_oe
);
   // Edge helper used for every sampled line
   function automatic logic rise(input logic prev, input logic cur);
      return !prev && cur;
   endfunction

   logic [3:0]                    dsel;          // Clamped decimation select
   logic [acc_pkg::DEC_CNT_W-1:0] dec_target;    // 2**(sel+1)
   logic [acc_pkg::DEC_CNT_W-1:0] dec_cnt_reg;   // Ready pulses counted
   logic                          decim_ff_reg;  // Decimation flop, 1 = select low
   logic                          word_ready_n_q_reg;    // Last ready level
   logic                          sel_q_reg;     // Last select level
   logic                          sclk_q_reg;    // Last converter clock level
   logic                          ack_q_reg;     // Last acknowledge level
   logic                          ack_seen_reg;  // Acknowledge since last update
   logic                          eff_sel_n;     // Select that reaches converter
   logic                          baud_clk;      // Divided baud clock
   acc_pkg::acc_cap_type          cap_reg;       // Capture state
   logic [acc_pkg::WORD_W-1:0]    shift_reg;     // Serial to parallel shifter
   logic [acc_pkg::BIT_CNT_W-1:0] bit_cnt_reg;   // Bits shifted this word
   logic [acc_pkg::WORD_W-1:0]    hold_reg;      // Word on the parallel port
   logic                          push;          // Whole word into queue
   logic                          q_in_ready;    // Queue has room
   logic                          q_out_valid;   // Queue holds a word
   logic [acc_pkg::WORD_W-1:0]    q_out_data;    // Oldest queued word
   logic                          pop;           // Word moves to port
   logic                          ack_rise;      // Acknowledge edge
   logic                          sel_fall;      // Select went low
   logic                          sel_rise;      // Select returned high
   logic                          load_ok;       // Capture may start
   logic [acc_pkg::BYTE_W-1:0]    byte_mux;      // Byte chosen in byte mode

   // Decimation ratio
   // ratio decode
   always_comb begin
      dsel = (decim_sel > acc_pkg::DEC_SEL_MAX) ? acc_pkg::DEC_SEL_MAX : decim_sel;
      dec_target = acc_pkg::DEC_ONE << (dsel + 4'h1);
   end

   // select routing
   // Remote select passes straight through when the counter is not driving
   assign eff_sel_n = decim_drive_en ? !decim_ff_reg : remote_select_n;

   // Edge sampling of the converter and reader lines
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_ready_n_q_reg <= 1'b1;
         sel_q_reg <= 1'b1;
         sclk_q_reg <= 1'b0;
         ack_q_reg <= 1'b0;
      end else begin
         word_ready_n_q_reg <= word_ready_n;
         sel_q_reg <= select_line_bar;
         sclk_q_reg <= serial_clock_conv;
         ack_q_reg <= read_acknowledge;
      end
   end

   assign ack_rise = rise(ack_q_reg, read_acknowledge);
   assign sel_fall = rise(select_line_bar, sel_q_reg);
   assign sel_rise = rise(sel_q_reg, select_line_bar);

   // Decimation counter and its flop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dec_cnt_reg <= '0;
         decim_ff_reg <= 1'b0;
      end else if (decim_ff_reg && rise(word_ready_n_q_reg, word_ready_n)) begin
         decim_ff_reg <= 1'b0;
         dec_cnt_reg <= '0;
      end else if (!decim_ff_reg && rise(word_ready_n, word_ready_n_q_reg)) begin
         dec_cnt_reg <= dec_cnt_reg + acc_pkg::DEC_ONE;
         if (dec_cnt_reg + acc_pkg::DEC_ONE == dec_target) begin
            decim_ff_reg <= 1'b1;
         end
      end
   end

   // Pins toward converter and reader, all registered
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         select_line_bar <= 1'b1;
         serial_clock_drive <= 1'b0;
         word_ready_bar <= 1'b1;
         serial_out_pin <= 1'b1;
         clear_to_send <= 1'b1;
      end else begin
         select_line_bar <= eff_sel_n;
         serial_clock_drive <= baud_clk_en ? baud_clk : serial_clock_in;
         word_ready_bar <= word_ready_n;
         serial_out_pin <= serial_data_out;
         clear_to_send <= (mode_sel == acc_pkg::MODE_ASYNC) ? word_ready_n : 1'b1;
      end
   end

   assign load_ok = q_in_ready && (!lockout_en || (ack_seen_reg && !parallel_ready_flag));

   // Serial capture, self-clocked mode only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_reg <= acc_pkg::CAP_IDLE;
         bit_cnt_reg <= '0;
         shift_reg <= '0;
      end else begin
         unique case (cap_reg)
            acc_pkg::CAP_IDLE: begin
               bit_cnt_reg <= '0;
               if (sel_fall && mode_sel == acc_pkg::MODE_SELF) begin
                  cap_reg <= load_ok ? acc_pkg::CAP_SHIFT : acc_pkg::CAP_SKIP;
               end
            end
            acc_pkg::CAP_SHIFT: begin
               if (rise(sclk_q_reg, serial_clock_conv) && bit_cnt_reg != acc_pkg::WORD_BITS) begin
                  shift_reg <= {shift_reg[acc_pkg::WORD_W-2:0], serial_data_out};
                  bit_cnt_reg <= bit_cnt_reg + 1'b1;
               end
               if (sel_rise) begin
                  cap_reg <= acc_pkg::CAP_IDLE;
               end
            end
            acc_pkg::CAP_SKIP: begin
               // Word passes unseen; the reader still owes an acknowledge
               if (sel_rise) begin
                  cap_reg <= acc_pkg::CAP_IDLE;
               end
            end
         endcase
      end
   end

   // word complete
   // Short words from a badly timed select are dropped, not queued
   assign push = (cap_reg == acc_pkg::CAP_SHIFT) && sel_rise
                 && (bit_cnt_reg == acc_pkg::WORD_BITS);

   acc_fifo #(
      .W (acc_pkg::WORD_W),
      .D (acc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (push),
      .in_ready  (q_in_ready),
      .in_data   (shift_reg),
      .out_valid (q_out_valid),
      .out_ready (!parallel_ready_flag),
      .out_data  (q_out_data)
   );

   assign pop = q_out_valid && !parallel_ready_flag;

   // Ready flag and holding word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         parallel_ready_flag <= 1'b0;
         ack_seen_reg <= 1'b1;
         hold_reg <= '0;
      end else begin
         if (pop) begin
            parallel_ready_flag <= 1'b1;
            hold_reg <= q_out_data;
         end else if (ack_rise) begin
            parallel_ready_flag <= 1'b0;
         end
         // New acknowledge wins over the update that clears it
         if (ack_rise) begin
            ack_seen_reg <= 1'b1;
         end else if (push) begin
            ack_seen_reg <= 1'b0;
         end
      end
   end

   assign byte_mux = byte_select ? hold_reg[acc_pkg::WORD_W-1:acc_pkg::BYTE_W]
                                 : hold_reg[acc_pkg::BYTE_W-1:0];

   // Three-state parallel port, one enable per byte lane
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_lane
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               par_data_o[gi*acc_pkg::BYTE_W +: acc_pkg::BYTE_W] <= '0;
               par_data_oe[gi] <= 1'b0;
            end else if (byte_wide_en) begin
               // Byte mode: both bytes share the low lane
               par_data_o[gi*acc_pkg::BYTE_W +: acc_pkg::BYTE_W] <= (gi == 0) ? byte_mux : '0;
               par_data_oe[gi] <= (gi == 0) && !read_enable_n;
            end else begin
               par_data_o[gi*acc_pkg::BYTE_W +: acc_pkg::BYTE_W] <=
                  hold_reg[gi*acc_pkg::BYTE_W +: acc_pkg::BYTE_W];
               par_data_oe[gi] <= !read_enable_n;
            end
         end
      end
   endgenerate

   acc_baud_div u_baud (
      .clk      (clk),
      .rst_n    (rst_n),
      .baud_exp (baud_exp),
      .baud_clk (baud_clk)
   );

   // Checks
   a_flag_on_pop: assert property (@(posedge clk) disable iff (!rst_n)
      pop |=> parallel_ready_flag && hold_reg == $past(q_out_data))
      else $error("ready flag not raised on port update");

   a_lock_skip: assert property (@(posedge clk) disable iff (!rst_n)
      cap_reg == acc_pkg::CAP_IDLE && sel_fall && mode_sel == acc_pkg::MODE_SELF
      && lockout_en && parallel_ready_flag |=> cap_reg == acc_pkg::CAP_SKIP)
      else $error("capture started while locked out");

   a_ack_needed: assert property (@(posedge clk) disable iff (!rst_n)
      push && lockout_en && !read_acknowledge ##1 (lockout_en && !ack_rise)
      |-> !ack_seen_reg)
      else $error("update did not consume acknowledge");

   a_ack_clears: assert property (@(posedge clk) disable iff (!rst_n)
      parallel_ready_flag && ack_rise |=> !parallel_ready_flag)
      else $error("acknowledge did not clear ready flag");

   a_sel_route: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 select_line_bar == $past(eff_sel_n))
      else $error("select does not follow chosen source");

   a_dec_fire: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(decim_ff_reg) |-> dec_cnt_reg == $past(dec_target) && !word_ready_n)
      else $error("select enabled at wrong count");

   a_dec_clear: assert property (@(posedge clk) disable iff (!rst_n)
      decim_ff_reg && !word_ready_n_q_reg && word_ready_n |=> !decim_ff_reg && dec_cnt_reg == '0)
      else $error("decimation flop not cleared on ready high");

   a_cts_follow: assert property (@(posedge clk) disable iff (!rst_n)
      mode_sel == acc_pkg::MODE_ASYNC |=> clear_to_send == $past(word_ready_n))
      else $error("clear to send does not track ready");

   a_word_len: assert property (@(posedge clk) disable iff (!rst_n)
      push |-> bit_cnt_reg == acc_pkg::WORD_BITS && sel_q_reg == 1'b0)
      else $error("partial word queued");
endmodule

// ---- src/acc_fifo.sv ----
`timescale 1ns/100ps
module acc_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Filling side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Draining side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(D);

   logic [W-1:0]  mem_reg [D];   // Word storage
   logic [AW-1:0] wr_ptr_reg;    // Next slot to write
   logic [AW-1:0] rd_ptr_reg;    // Oldest word
   logic [AW:0]   count_reg;     // Words held
   logic          push;
   logic          pop;

   // Handshakes; full and empty come straight from the count
   assign in_ready = (count_reg != FULL_CNT);
   assign out_valid = (count_reg != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_reg[rd_ptr_reg];

   // Storage write, no reset needed on data
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Never accepts a word while full
   a_fifo_no_over: assert property (@(posedge clk) disable iff (!rst_n)
      count_reg == FULL_CNT && !pop |=> count_reg == FULL_CNT)
      else $error("fifo count moved past full");
endmodule

// ---- tb/acc_conv_model.sv ----
`timescale 1ns/100ps
// Converter stand-in: ready pulses, one self-clocked frame when selected
module acc_conv_model (
   // Clock
   input  wire logic        clk,
   // Bench control
   input  wire logic        run,
   input  wire logic        count_mode,
   input  wire logic [15:0] word_in,
   // Select from the block
   input  wire logic        select_line_bar,
   // Converter outputs
   output logic             word_ready_n,
   output logic             serial_clock_conv,
   output logic             serial_data_out
);
   logic [15:0] frame_cnt;   // Frames sent while counting
   logic [15:0] word;        // Word of the current frame

   // Ready pulse; a frame only if select went low meanwhile
   initial begin
      word_ready_n = 1'b1;
      serial_clock_conv = 1'b0;
      serial_data_out = 1'b1;
      frame_cnt = 16'h0000;
      word = 16'h0000;
      forever begin
         @(negedge clk);
         // Numbering restarts whenever the bench idles the model
         if (!count_mode || !run) frame_cnt = 16'h0000;
         if (run) begin
            // Port is not checked here; ready falls on every pass
            word_ready_n = 1'b0;
            repeat (6) @(negedge clk);
            if (!select_line_bar) begin
               word = word_in + frame_cnt;
               frame_cnt = frame_cnt + 16'h0001;
               // MSB first, clock runs only inside the frame
               for (int i = 15; i >= 0; i--) begin
                  serial_data_out = word[i];
                  repeat (2) @(negedge clk);
                  serial_clock_conv = 1'b1;
                  repeat (2) @(negedge clk);
                  serial_clock_conv = 1'b0;
               end
               // Released line shows the inverse, never a stale bit
               serial_data_out = ~serial_data_out;
            end
            repeat (2) @(negedge clk);
            word_ready_n = 1'b1;
            repeat (10) @(negedge clk);
         end
      end
   end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
   // Clock, reset, counters
   logic        clk, rst_n;
   int          fail_count, num_checks, cycles;
   // Configuration inputs
   logic [1:0]  mode_sel;
   logic [3:0]  decim_sel, baud_exp;
   logic        decim_drive_en, lockout_en, byte_wide_en, baud_clk_en;
   // Converter side
   logic        word_ready_n, serial_clock_conv, serial_data_out;
   logic        select_line_bar, serial_clock_drive;
   // Remote side
   logic        remote_select_n, serial_clock_in, read_acknowledge, read_enable_n;
   logic        byte_select, parallel_ready_flag, word_ready_bar, serial_out_pin;
   logic        clear_to_send;
   logic [15:0] par_data_o;
   logic [1:0]  par_data_oe;
   // Model control
   logic        run, count_mode;
   logic [15:0] word_in;
   int          n;

   acc_capture acc_capture_inst (.clk(clk), .rst_n(rst_n), .mode_sel(mode_sel),
      .decim_sel(decim_sel), .decim_drive_en(decim_drive_en), .lockout_en(lockout_en),
      .byte_wide_en(byte_wide_en), .baud_clk_en(baud_clk_en), .baud_exp(baud_exp),
      .word_ready_n(word_ready_n), .serial_clock_conv(serial_clock_conv),
      .serial_data_out(serial_data_out), .select_line_bar(select_line_bar),
      .serial_clock_drive(serial_clock_drive), .remote_select_n(remote_select_n),
      .serial_clock_in(serial_clock_in), .read_acknowledge(read_acknowledge),
      .read_enable_n(read_enable_n), .byte_select(byte_select),
      .parallel_ready_flag(parallel_ready_flag), .word_ready_bar(word_ready_bar),
      .serial_out_pin(serial_out_pin), .clear_to_send(clear_to_send),
      .par_data_o(par_data_o), .par_data_oe(par_data_oe));

   acc_conv_model acc_conv_model_inst (.clk(clk), .run(run), .count_mode(count_mode),
      .word_in(word_in), .select_line_bar(select_line_bar), .word_ready_n(word_ready_n),
      .serial_clock_conv(serial_clock_conv), .serial_data_out(serial_data_out));

   // Free-running 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 50000) begin
         fail_count++;
         finish_test();
      end
   end

   // Compare and count
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task step(input int c);
      repeat (c) @(negedge clk);
   endtask

   // Bounded wait: 0 flag, 1 ready, else select
   task wait_on(input int which, input logic lvl);
      logic v;
      int   g;
      for (g = 0; g < 3000; g++) begin
         case (which)
            0: v = parallel_ready_flag;
            1: v = word_ready_n;
            default: v = select_line_bar;
         endcase
         if (v === lvl) break;
         step(1);
      end
      if (g == 3000) check("wait", 16'h0000, 16'h0001);
   endtask

   // Reset held six cycles; model let go idle first so no pulse spans release
   task do_reset();
      run = 1'b0;
      wait_on(1, 1'b1);
      step(14);
      rst_n = 1'b0;
      step(6);
      rst_n = 1'b1;
      step(1);
   endtask

   // One-cycle acknowledge, seen on one rising edge
   task ack();
      read_acknowledge = 1'b1;
      step(1);
      read_acknowledge = 1'b0;
   endtask

   task t_reset();
      do_reset();
      check("select", 16'(select_line_bar), 16'h0001);
      check("flag", 16'(parallel_ready_flag), 16'h0000);
      check("oe", 16'(par_data_oe), 16'h0000);
      check("data", par_data_o, 16'h0000);
      check("cts", 16'(clear_to_send), 16'h0001);
      $display("test reset done");
   endtask

   // Lockout holds the first word until acknowledged
   task t_lock();
      word_in = 16'ha55a;
      do_reset();
      run = 1'b1;
      wait_on(0, 1'b1);
      read_enable_n = 1'b0;
      word_in = 16'h3cc3;
      step(2);
      check("word", par_data_o, 16'ha55a);
      check("oe", 16'(par_data_oe), 16'h0003);
      step(400);
      check("flag held", 16'(parallel_ready_flag), 16'h0001);
      check("word held", par_data_o, 16'ha55a);
      ack();
      step(1);
      check("flag clear", 16'(parallel_ready_flag), 16'h0000);
      wait_on(0, 1'b1);
      step(1);
      check("next word", par_data_o, 16'h3cc3);
      read_enable_n = 1'b1;
      step(2);
      check("oe off", 16'(par_data_oe), 16'h0000);
      $display("test lock done");
   endtask

   // Byte reads on lane 0
   task t_byte();
      word_in = 16'hc35a;
      byte_wide_en = 1'b1;
      do_reset();
      run = 1'b1;
      wait_on(0, 1'b1);
      read_enable_n = 1'b0;
      byte_select = 1'b1;
      step(2);
      check("high byte", 16'(par_data_o[7:0]), 16'h00c3);
      check("lane oe", 16'(par_data_oe), 16'h0001);
      byte_select = 1'b0;
      step(2);
      check("low byte", 16'(par_data_o[7:0]), 16'h005a);
      read_enable_n = 1'b1;
      byte_wide_en = 1'b0;
      $display("test byte done");
   endtask

   // No lockout: queue fills while reader stalls, then drains in order
   task t_fifo();
      lockout_en = 1'b0;
      count_mode = 1'b1;
      word_in = 16'h1000;
      do_reset();
      run = 1'b1;
      step(1600);
      run = 1'b0;
      step(150);
      for (int i = 0; i <= acc_pkg::FIFO_DEPTH; i++) begin
         wait_on(0, 1'b1);
         step(1);
         check("queued word", par_data_o, 16'h1000 + 16'(i));
         ack();
         wait_on(0, 1'b0);
      end
      step(100);
      check("queue empty", 16'(parallel_ready_flag), 16'h0000);
      lockout_en = 1'b1;
      count_mode = 1'b0;
      $display("test fifo done");
   endtask

   // Remote select, divide setting zero, sequenced against ready
   task t_remote();
      decim_drive_en = 1'b0;
      word_in = 16'h9669;
      do_reset();
      run = 1'b1;
      wait_on(1, 1'b0);
      // Select only while a word is ready
      remote_select_n = 1'b0;
      step(2);
      check("remote select", 16'(select_line_bar), 16'h0000);
      wait_on(1, 1'b1);
      remote_select_n = 1'b1;
      wait_on(0, 1'b1);
      step(1);
      check("remote word", par_data_o, 16'h9669);
      check("serial pin", 16'(serial_out_pin), 16'(serial_data_out));
      check("ready copy", 16'(word_ready_bar), 16'(word_ready_n));
      ack();
      $display("test remote done");
   endtask

   // Ready pulses between select activations
   task t_decim();
      int cnt;
      logic prev;
      decim_drive_en = 1'b1;
      for (int s = 0; s < 4; s++) begin
         decim_sel = 4'(s);
         do_reset();
         run = 1'b1;
         wait_on(2, 1'b0);
         wait_on(2, 1'b1);
         cnt = 0;
         prev = word_ready_n;
         for (int g = 0; g < 3000 && select_line_bar === 1'b1; g++) begin
            step(1);
            if (prev === 1'b1 && word_ready_n === 1'b0) cnt++;
            prev = word_ready_n;
         end
         check("pulses", 16'(cnt), 16'h0002 << s);
      end
      decim_sel = 4'h0;
      $display("test decim done");
   endtask

   // Rise-to-rise cycles of the driven serial clock
   task period(output int c);
      int g;
      g = 0;
      while (serial_clock_drive !== 1'b0 && g < 9000) begin step(1); g++; end
      while (serial_clock_drive !== 1'b1 && g < 9000) begin step(1); g++; end
      c = 0;
      while (serial_clock_drive !== 1'b0 && c < 9000) begin step(1); c++; end
      while (serial_clock_drive !== 1'b1 && c < 9000) begin step(1); c++; end
   endtask

   // Character mode clear-to-send, baud divider, supplied clock
   task t_modes();
      decim_drive_en = 1'b0;
      mode_sel = acc_pkg::MODE_ASYNC;
      do_reset();
      run = 1'b1;
      wait_on(1, 1'b0);
      step(2);
      check("cts ready", 16'(clear_to_send), 16'h0000);
      mode_sel = acc_pkg::MODE_SELF;
      step(3);
      check("cts idle", 16'(clear_to_send), 16'h0001);
      // Framing is the converter's; block paces it only
      baud_clk_en = 1'b1;
      for (int e = 8; e <= 12; e++) begin
         baud_exp = 4'(e);
         period(n);
         period(n);
         check("baud period", 16'(n), 16'h0001 << e);
      end
      baud_clk_en = 1'b0;
      mode_sel = acc_pkg::MODE_EXT;
      serial_clock_in = 1'b1;
      step(2);
      check("ext clock hi", 16'(serial_clock_drive), 16'h0001);
      serial_clock_in = 1'b0;
      step(2);
      check("ext clock lo", 16'(serial_clock_drive), 16'h0000);
      $display("test modes done");
   endtask

   task finish_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Inputs set at time zero, then the scenarios
   initial begin
      fail_count = 0;
      num_checks = 0;
      cycles = 0;
      rst_n = 1'b0;
      mode_sel = acc_pkg::MODE_SELF;
      decim_sel = 4'h0;
      baud_exp = acc_pkg::BAUD_EXP_MIN;
      decim_drive_en = 1'b1;
      lockout_en = 1'b1;
      byte_wide_en = 1'b0;
      baud_clk_en = 1'b0;
      remote_select_n = 1'b1;
      serial_clock_in = 1'b0;
      read_acknowledge = 1'b0;
      read_enable_n = 1'b1;
      byte_select = 1'b0;
      run = 1'b0;
      count_mode = 1'b0;
      word_in = 16'h0000;
      t_reset();
      t_lock();
      t_byte();
      t_fifo();
      t_remote();
      t_decim();
      t_modes();
      finish_test();
   end
endmodule
